// [hdl/ise_consts.vh]
// constants for the instruction subset executor
`ifndef ISE_CONSTS_VH
`define ISE_CONSTS_VH
// opcode patterns
`define ISE_LDPTR1_MASK 16'hFFC0
`define ISE_LDPTR1_CODE 16'hEE00
`define ISE_LDPTR2_MASK 16'hFF00
`define ISE_LDPTR2_CODE 16'hF000
`define ISE_MOVE_MASK 16'hFC00
`define ISE_MOVE_CODE 16'h5000
`define ISE_RELCALL_MASK 16'hF800
`define ISE_RELCALL_CODE 16'hD800
`define ISE_RESET_CODE 16'h00FF
`define ISE_TBLWR_MASK 16'hFFFC
`define ISE_TBLWR_CODE 16'h000C
// instruction fields
`define ISE_PSEL_HI 5
`define ISE_PSEL_LO 4
`define ISE_KHI_HI 3
`define ISE_KHI_LO 0
`define ISE_KLO_HI 7
`define ISE_KLO_LO 0
`define ISE_MOVE_D_BIT 9
`define ISE_MOVE_A_BIT 8
`define ISE_FADDR_HI 7
`define ISE_FADDR_LO 0
`define ISE_RELCALL_N_HI 10
`define ISE_RELCALL_N_LO 0
`define ISE_RELCALL_SIGN 10
`define ISE_TBL_MODE_HI 1
`define ISE_TBL_MODE_LO 0
// table write modes
`define ISE_TBL_NONE 2'h0
`define ISE_TBL_POSTINC 2'h1
`define ISE_TBL_POSTDEC 2'h2
`define ISE_TBL_PREINC 2'h3
// access bank split and upper bank
`define ISE_ACC_SPLIT 8'h60
`define ISE_ACC_LOW_BANK 4'h0
`define ISE_ACC_HIGH_BANK 4'hF
// program counter step
`define ISE_PC_STEP 21'h00_0002
// register port map
`define ISE_REG_BANK 3'h0
`define ISE_REG_LATCH 3'h1
`define ISE_REG_PTR_L 3'h2
`define ISE_REG_PTR_H 3'h3
`define ISE_REG_PTR_U 3'h4
`define ISE_REG_WORK 3'h5
`define ISE_REG_STATUS 3'h6
`define ISE_REG_PC_L 3'h7
// reset values
`define ISE_RST_PC 21'h00_0000
`define ISE_RST_BYTE 8'h00
`define ISE_RST_PTR 21'h00_0000
`define ISE_RST_FPTR 12'h000
`endif

// [hdl/ise_decode.v]
// opcode class decoder
`timescale 1ns/1ps
`include "ise_consts.vh"
module ise_decode (
  // instruction word
  input wire [15:0] instr_in,
  // class flags
  output wire is_ldptr_out,
  output wire is_move_out,
  output wire is_call_out,
  output wire is_reset_out,
  output wire is_tblwr_out
);
  assign is_ldptr_out = (instr_in & `ISE_LDPTR1_MASK) == `ISE_LDPTR1_CODE;
  assign is_move_out = (instr_in & `ISE_MOVE_MASK) == `ISE_MOVE_CODE;
  assign is_call_out = (instr_in & `ISE_RELCALL_MASK) == `ISE_RELCALL_CODE;
  assign is_reset_out = instr_in == `ISE_RESET_CODE; // RL7
  assign is_tblwr_out = (instr_in & `ISE_TBLWR_MASK) == `ISE_TBLWR_CODE;
endmodule // ise_decode

// [hdl/ise_table_pointer_step.v]
// table pointer update arithmetic
`timescale 1ns/1ps
`include "ise_consts.vh"
module ise_table_pointer_step #(
  parameter PTR_W = 21
) (
  // current pointer and mode
  input wire [PTR_W-1:0] ptr_in,
  input wire [1:0] mode_in,
  // pointer used for the write and pointer after it
  output wire [PTR_W-1:0] use_ptr_out,
  output reg [PTR_W-1:0] fin_ptr_out
);
  function [PTR_W-1:0] step;
    input [PTR_W-1:0] p;
    input up;
    begin
      step = up ? p + {{(PTR_W-1){1'b0}}, 1'b1} : p - {{(PTR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // pre-increment moves before selecting the holding register
  assign use_ptr_out = (mode_in == `ISE_TBL_PREINC) ? step(ptr_in, 1'b1) : ptr_in; // RL14
  always @* begin
    case (mode_in) // RL12
      `ISE_TBL_POSTINC: fin_ptr_out = step(ptr_in, 1'b1);
      `ISE_TBL_POSTDEC: fin_ptr_out = step(ptr_in, 1'b0);
      `ISE_TBL_PREINC: fin_ptr_out = step(ptr_in, 1'b1);
      default: fin_ptr_out = ptr_in;
    endcase
  end
endmodule // ise_table_pointer_step

// [hdl/ise_exec.v]
// instruction subset executor: pointer load, move file, relative call, soft reset, table write
`timescale 1ns/1ps
`include "ise_consts.vh"
// How it works
// [RL1] pointer load takes two words; first writes literal upper bits to pointer high byte
// [RL2] second word writes low eight literal bits to pointer low byte
// [RL3] move file: access bit zero uses access bank, one uses bank select
// [RL4] relative call pushes current address plus two onto return stack
// [RL5] new address is incremented address plus twice signed 11-bit offset
// [RL6] relative call takes two cycles, second cycle does nothing
// [RL7] soft reset opcode returns all master clear registers to reset values
// [RL8] soft reset is one word, one cycle, reset starts inside it; here the clear lands one clock later
// [RL9] three low pointer bits pick one of eight holding registers
// [RL10] table pointer is 21 bits addressing bytes of program memory
// [RL11] pointer bit 0 picks low or high byte of program word
// [RL12] two-bit mode: none, post-increment, post-decrement, pre-increment by one
// [RL13] move file writes working register or back to file, sets negative and zero
// [RL14] pre-increment moves pointer before choosing holding register and byte
module ise_exec #(
  parameter PTR_W = 21,
  parameter PC_W = 21
) (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // instruction fetch
  input wire instr_valid_in,
  input wire [15:0] instr_in,
  output reg instr_ready_out,
  output reg [PC_W-1:0] pc_out,
  // register port
  input wire [2:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // data register file
  output reg file_rd_out,
  output reg file_we_out,
  output reg [11:0] file_addr_out,
  output reg [7:0] file_wdata_out,
  input wire [7:0] file_rdata_in,
  // file select pointers, three of 12 bits
  output reg [35:0] fptr_out,
  // return stack
  output reg stack_push_out,
  output reg [PC_W-1:0] stack_top_out,
  // program memory holding latches
  output reg hold_we_out,
  output reg [2:0] hold_sel_out,
  output reg hold_byte_hi_out,
  output reg [7:0] hold_data_out,
  // soft reset indication
  output reg soft_reset_out
);
  localparam ST_RUN = 4'b0001;
  localparam ST_LDPTR2 = 4'b0010;
  localparam ST_MOVE = 4'b0100;
  localparam ST_WAIT = 4'b1000;

  wire is_ldptr;
  wire is_move;
  wire is_call;
  wire is_reset;
  wire is_tblwr;
  wire take;
  wire rst;
  wire [PTR_W-1:0] use_ptr;
  wire [PTR_W-1:0] fin_ptr;
  wire [PC_W-1:0] pc_inc;
  wire [PC_W-1:0] rel_off;

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [7:0] bank_ff;
  reg [7:0] latch_ff;
  reg [PTR_W-1:0] ptr_ff;
  reg [7:0] work_ff;
  reg neg_ff;
  reg zero_ff;
  reg [1:0] psel_ff;
  reg dest_ff;
  reg tbl_pend_ff;
  reg [PTR_W-1:0] tbl_use_ff;
  reg [PTR_W-1:0] tbl_fin_ff;

  ise_decode u_dec (
    .instr_in(instr_in),
    .is_ldptr_out(is_ldptr),
    .is_move_out(is_move),
    .is_call_out(is_call),
    .is_reset_out(is_reset),
    .is_tblwr_out(is_tblwr)
  );

  ise_table_pointer_step #(
    .PTR_W(PTR_W)
  ) u_step (
    .ptr_in(ptr_ff),
    .mode_in(instr_in[`ISE_TBL_MODE_HI:`ISE_TBL_MODE_LO]),
    .use_ptr_out(use_ptr),
    .fin_ptr_out(fin_ptr)
  );

  // soft reset acts as a master clear one clock later
  assign rst = reset_in | soft_reset_out; // RL7
  assign take = instr_valid_in & instr_ready_out;
  assign pc_inc = pc_out + `ISE_PC_STEP; // RL4
  // twice the sign-extended offset
  assign rel_off = {{(PC_W-12){instr_in[`ISE_RELCALL_SIGN]}}, instr_in[`ISE_RELCALL_N_HI:`ISE_RELCALL_N_LO], 1'b0}; // RL5

  function [11:0] bank_addr;
    input [7:0] f;
    input a;
    input [7:0] bank;
    begin
      if (a) begin
        bank_addr = {bank[3:0], f}; // RL3
      end else if (f < `ISE_ACC_SPLIT) begin
        bank_addr = {`ISE_ACC_LOW_BANK, f}; // RL3
      end else begin
        bank_addr = {`ISE_ACC_HIGH_BANK, f};
      end
    end
  endfunction

  // next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (take && is_ldptr) begin
          nxt_state = ST_LDPTR2; // RL1
        end else if (take && is_move) begin
          nxt_state = ST_MOVE;
        end else if (take && (is_call || is_tblwr)) begin
          nxt_state = ST_WAIT; // RL6
        end
      end
      ST_LDPTR2: begin
        if (take) begin
          nxt_state = ST_RUN;
        end
      end
      ST_MOVE: nxt_state = ST_RUN;
      ST_WAIT: nxt_state = ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
  end

  // sequencing, program counter and stack
  always @(posedge clk_in) begin
    if (rst) begin
      state_ff <= ST_RUN;
      pc_out <= `ISE_RST_PC;
      instr_ready_out <= 1'b1;
      stack_push_out <= 1'b0;
      stack_top_out <= `ISE_RST_PC;
      psel_ff <= 2'h0;
      dest_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      stack_push_out <= 1'b0;
      instr_ready_out <= (nxt_state == ST_RUN) || (nxt_state == ST_LDPTR2);
      if (take && state_ff == ST_RUN && is_call) begin
        stack_push_out <= 1'b1; // RL4
        stack_top_out <= pc_inc; // RL4
        pc_out <= pc_inc + rel_off; // RL5
      end else if (take) begin
        pc_out <= pc_inc;
      end
      if (take && state_ff == ST_RUN && is_ldptr) begin
        psel_ff <= instr_in[`ISE_PSEL_HI:`ISE_PSEL_LO];
      end
      if (take && state_ff == ST_RUN && is_move) begin
        dest_ff <= instr_in[`ISE_MOVE_D_BIT];
      end
    end
  end

  // soft reset request: one word, one cycle, registered so the reset starts one clock later
  always @(posedge clk_in) begin
    if (reset_in) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= take && state_ff == ST_RUN && is_reset && !soft_reset_out; // RL8
    end
  end

  // file select pointers
  always @(posedge clk_in) begin
    if (rst) begin
      fptr_out <= {3{`ISE_RST_FPTR}};
    end else if (take && state_ff == ST_RUN && is_ldptr) begin
      case (instr_in[`ISE_PSEL_HI:`ISE_PSEL_LO])
        2'h0: fptr_out[11:8] <= instr_in[`ISE_KHI_HI:`ISE_KHI_LO]; // RL1
        2'h1: fptr_out[23:20] <= instr_in[`ISE_KHI_HI:`ISE_KHI_LO]; // RL1
        2'h2: fptr_out[35:32] <= instr_in[`ISE_KHI_HI:`ISE_KHI_LO]; // RL1
        default: fptr_out <= fptr_out;
      endcase
    end else if (take && state_ff == ST_LDPTR2) begin
      case (psel_ff)
        2'h0: fptr_out[7:0] <= instr_in[`ISE_KLO_HI:`ISE_KLO_LO]; // RL2
        2'h1: fptr_out[19:12] <= instr_in[`ISE_KLO_HI:`ISE_KLO_LO]; // RL2
        2'h2: fptr_out[31:24] <= instr_in[`ISE_KLO_HI:`ISE_KLO_LO]; // RL2
        default: fptr_out <= fptr_out;
      endcase
    end
  end

  // move file: read request, then write result and flags
  always @(posedge clk_in) begin
    if (rst) begin
      file_rd_out <= 1'b0;
      file_we_out <= 1'b0;
      file_addr_out <= 12'h000;
      file_wdata_out <= `ISE_RST_BYTE;
      work_ff <= `ISE_RST_BYTE;
      neg_ff <= 1'b0;
      zero_ff <= 1'b0;
    end else begin
      file_rd_out <= 1'b0;
      file_we_out <= 1'b0;
      if (take && state_ff == ST_RUN && is_move) begin
        file_rd_out <= 1'b1;
        file_addr_out <= bank_addr(instr_in[`ISE_FADDR_HI:`ISE_FADDR_LO], instr_in[`ISE_MOVE_A_BIT], bank_ff); // RL3
      end
      if (state_ff == ST_MOVE) begin
        neg_ff <= file_rdata_in[7]; // RL13
        zero_ff <= file_rdata_in == 8'h00; // RL13
        if (dest_ff) begin
          file_we_out <= 1'b1; // RL13
          file_wdata_out <= file_rdata_in;
        end else begin
          work_ff <= file_rdata_in; // RL13
        end
      end else if (reg_wr_in && reg_addr_in == `ISE_REG_WORK) begin
        work_ff <= reg_wdata_in;
      end
    end
  end

  // table write: capture pointer in first cycle, write holding register in second
  always @(posedge clk_in) begin
    if (rst) begin
      tbl_pend_ff <= 1'b0;
      tbl_use_ff <= `ISE_RST_PTR;
      tbl_fin_ff <= `ISE_RST_PTR;
      hold_we_out <= 1'b0;
      hold_sel_out <= 3'h0;
      hold_byte_hi_out <= 1'b0;
      hold_data_out <= `ISE_RST_BYTE;
    end else begin
      hold_we_out <= 1'b0;
      tbl_pend_ff <= take && state_ff == ST_RUN && is_tblwr;
      if (take && state_ff == ST_RUN && is_tblwr) begin
        tbl_use_ff <= use_ptr; // RL14
        tbl_fin_ff <= fin_ptr; // RL12
      end
      if (tbl_pend_ff) begin
        hold_we_out <= 1'b1;
        hold_sel_out <= tbl_use_ff[2:0]; // RL9
        hold_byte_hi_out <= tbl_use_ff[0]; // RL11
        hold_data_out <= latch_ff;
      end
    end
  end

  // software registers and the 21-bit byte pointer
  always @(posedge clk_in) begin
    if (rst) begin
      bank_ff <= `ISE_RST_BYTE;
      latch_ff <= `ISE_RST_BYTE;
      ptr_ff <= `ISE_RST_PTR;
    end else begin
      if (reg_wr_in && reg_addr_in == `ISE_REG_BANK) begin
        bank_ff <= {4'h0, reg_wdata_in[3:0]};
      end
      if (reg_wr_in && reg_addr_in == `ISE_REG_LATCH) begin
        latch_ff <= reg_wdata_in;
      end
      if (tbl_pend_ff) begin
        ptr_ff <= tbl_fin_ff; // RL12
      end else if (reg_wr_in && reg_addr_in == `ISE_REG_PTR_L) begin
        ptr_ff[7:0] <= reg_wdata_in; // RL10
      end else if (reg_wr_in && reg_addr_in == `ISE_REG_PTR_H) begin
        ptr_ff[15:8] <= reg_wdata_in;
      end else if (reg_wr_in && reg_addr_in == `ISE_REG_PTR_U) begin
        ptr_ff[PTR_W-1:16] <= reg_wdata_in[PTR_W-17:0];
      end
    end
  end

  // register read, answer one cycle after the strobe
  always @(posedge clk_in) begin
    if (rst) begin
      reg_rdata_out <= `ISE_RST_BYTE;
    end else if (reg_rd_in) begin
      if (reg_addr_in == `ISE_REG_BANK) begin
        reg_rdata_out <= bank_ff;
      end else if (reg_addr_in == `ISE_REG_LATCH) begin
        reg_rdata_out <= latch_ff;
      end else if (reg_addr_in == `ISE_REG_PTR_L) begin
        reg_rdata_out <= ptr_ff[7:0];
      end else if (reg_addr_in == `ISE_REG_PTR_H) begin
        reg_rdata_out <= ptr_ff[15:8];
      end else if (reg_addr_in == `ISE_REG_PTR_U) begin
        reg_rdata_out <= {{(24-PTR_W){1'b0}}, ptr_ff[PTR_W-1:16]};
      end else if (reg_addr_in == `ISE_REG_WORK) begin
        reg_rdata_out <= work_ff;
      end else if (reg_addr_in == `ISE_REG_STATUS) begin
        reg_rdata_out <= {6'h00, neg_ff, zero_ff};
      end else begin
        reg_rdata_out <= pc_out[7:0];
      end
    end else begin
      reg_rdata_out <= `ISE_RST_BYTE;
    end
  end
endmodule // ise_exec

// [testbench/ise_monitor.sv]
// port assertions for the instruction subset executor
`timescale 1ns/1ps
module ise_monitor #(
  parameter PC_W = 21
) (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // fetch and register port
  input wire instr_valid_in,
  input wire [15:0] instr_in,
  input wire instr_ready_out,
  input wire [PC_W-1:0] pc_out,
  input wire [2:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  // far side
  input wire file_rd_out,
  input wire file_we_out,
  input wire [11:0] file_addr_out,
  input wire [7:0] file_wdata_out,
  input wire [7:0] file_rdata_in,
  input wire [35:0] fptr_out,
  input wire stack_push_out,
  input wire [PC_W-1:0] stack_top_out,
  input wire hold_we_out,
  input wire soft_reset_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  wire take = instr_valid_in && instr_ready_out;
  wire call_t = take && (instr_in & 16'hf800) == 16'hd800;
  wire ld1_t = take && (instr_in & 16'hffc0) == 16'hee00 && instr_in[5:4] != 2'h3;
  wire mf_t = take && (instr_in & 16'hfc00) == 16'h5000;
  wire tbl_t = take && (instr_in & 16'hfffc) == 16'h000c;
  wire [PC_W-1:0] pc_x2 = pc_out + {{(PC_W-2){1'b0}}, 2'h2};
  wire [PC_W-1:0] call_tgt = pc_x2 + {{(PC_W-12){instr_in[10]}}, instr_in[10:0], 1'b0};
  // pointer select and bank seen by the core
  reg [1:0] sel_ff;
  reg [3:0] bank_ff;
  wire [11:0] sel_ptr = fptr_out[sel_ff*12 +: 12];
  wire [11:0] mf_addr = instr_in[8] ? {bank_ff, instr_in[7:0]} :
    {(instr_in[7:0] < 8'h60) ? 4'h0 : 4'hf, instr_in[7:0]};
  always @(posedge clk_in) begin
    if (reset_in || soft_reset_out) begin
      sel_ff <= 2'h0;
      bank_ff <= 4'h0;
    end else begin
      if (ld1_t) begin
        sel_ff <= instr_in[5:4];
      end
      if (reg_wr_in && reg_addr_in == 3'h0) begin
        bank_ff <= reg_wdata_in[3:0];
      end
    end
  end
  a_call_push: assert property (call_t |=> stack_push_out && stack_top_out == $past(pc_x2))
    else $error("call return address wrong");
  a_call_target: assert property (call_t |=> pc_out == $past(call_tgt))
    else $error("call target wrong");
  a_call_bubble: assert property (call_t |=> !instr_ready_out ##1 instr_ready_out)
    else $error("call bubble wrong");
  a_soft_clear: assert property (take && instr_in == 16'h00ff |=> soft_reset_out ##1
    (!soft_reset_out && pc_out == {PC_W{1'b0}} && fptr_out == 36'h0_0000_0000))
    else $error("soft reset wrong");
  a_ptr_high: assert property (ld1_t |=> sel_ptr[11:8] == $past(instr_in[3:0]))
    else $error("pointer high wrong");
  a_ptr_low: assert property (ld1_t ##1 take |=> sel_ptr[7:0] == $past(instr_in[7:0]))
    else $error("pointer low wrong");
  a_tbl_slot: assert property (tbl_t |=> (!instr_ready_out && !hold_we_out) ##1 hold_we_out)
    else $error("table write timing wrong");
  a_file_addr: assert property (mf_t |=> file_rd_out && file_addr_out == $past(mf_addr))
    else $error("file address wrong");
  a_file_dest: assert property (mf_t |=> ##1 (file_we_out == $past(instr_in[9], 2)) &&
    (!file_we_out || file_wdata_out == $past(file_rdata_in)))
    else $error("file destination wrong");
  c_call: cover property (call_t);
  c_ptr: cover property (ld1_t ##1 take);
  c_mf_back: cover property (mf_t && instr_in[9]);
  c_tbl_pre: cover property (tbl_t && instr_in[1:0] == 2'h3);
endmodule // ise_monitor

bind ise_exec ise_monitor #(.PC_W(PC_W)) u_mon (.clk_in, .reset_in, .instr_valid_in, .instr_in,
  .instr_ready_out, .pc_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .file_rd_out, .file_we_out,
  .file_addr_out, .file_wdata_out, .file_rdata_in, .fptr_out, .stack_push_out, .stack_top_out,
  .hold_we_out, .soft_reset_out);

// [testbench/ise_file_model.sv]
// behavioural data register file behind the executor
`timescale 1ns/1ps
module ise_file_model (
  // clock
  input wire clk_in,
  // file port
  input wire file_rd_in,
  input wire file_we_in,
  input wire [11:0] file_addr_in,
  input wire [7:0] file_wdata_in,
  output wire [7:0] file_rdata_out
);
  reg [7:0] mem [0:4095];
  reg [7:0] junk_ff;
  integer i;
  initial begin
    for (i = 0; i < 4096; i = i + 1) begin
      mem[i] = i[7:0] ^ i[11:4];
    end
    junk_ff = 8'h00;
  end
  // no read: bus shows a changing pattern
  assign file_rdata_out = file_rd_in ? mem[file_addr_in] : junk_ff;
  always @(posedge clk_in) begin
    junk_ff <= ~junk_ff ^ file_addr_in[7:0];
    if (file_we_in) begin
      mem[file_addr_in] <= file_wdata_in;
    end
  end
endmodule // ise_file_model

// [testbench/instr_subset_exec_tb_top.sv]
// self-checking bench for the instruction subset executor
`timescale 1ns/1ps
module instr_subset_exec_tb_top;
  reg clk_in, reset_in, instr_valid_in, reg_wr_in, reg_rd_in;
  reg [15:0] instr_in;
  reg [2:0] reg_addr_in;
  reg [7:0] reg_wdata_in, f, v, lat;
  wire instr_ready_out, file_rd_out, file_we_out, stack_push_out, hold_we_out, hold_byte_hi_out, soft_reset_out;
  wire [20:0] pc_out, stack_top_out;
  wire [7:0] reg_rdata_out, file_wdata_out, file_rdata_in, hold_data_out;
  wire [11:0] file_addr_out;
  wire [35:0] fptr_out;
  wire [2:0] hold_sel_out;
  integer fail_count, total_checks, k;
  reg [31:0] rnd_state;
  reg [20:0] pc_exp, p, q;
  reg [11:0] lit;
  reg [10:0] n;
  reg [3:0] bank;
  ise_exec #(.PTR_W(21), .PC_W(21)) DUT (.clk_in, .reset_in, .instr_valid_in, .instr_in, .instr_ready_out,
    .pc_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .file_rd_out, .file_we_out,
    .file_addr_out, .file_wdata_out, .file_rdata_in, .fptr_out, .stack_push_out, .stack_top_out, .hold_we_out,
    .hold_sel_out, .hold_byte_hi_out, .hold_data_out, .soft_reset_out);
  ise_file_model u_file (.clk_in, .file_rd_in(file_rd_out), .file_we_in(file_we_out),
    .file_addr_in(file_addr_out), .file_wdata_in(file_wdata_out), .file_rdata_out(file_rdata_in));
  function [31:0] rnd_next(input [31:0] s);
    rnd_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [11:0] file_addr(input a, input [3:0] b, input [7:0] fa);
    file_addr = a ? {b, fa} : {(fa < 8'h60) ? 4'h0 : 4'hf, fa};
  endfunction
  function [7:0] file_init(input [11:0] a);
    file_init = a[7:0] ^ a[11:4];
  endfunction
  task chk(input [63:0] got, input [63:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  // entered and left just after a rising edge
  task issue(input [15:0] word, input keep);
    integer t;
    begin
      instr_valid_in <= 1'b1;
      instr_in <= word;
      t = 0;
      @(negedge clk_in);
      while (instr_ready_out !== 1'b1 && t < 20) begin
        t = t + 1;
        @(negedge clk_in);
      end
      chk(t < 20, 1'b1);
      @(posedge clk_in);
      if (!keep) begin
        instr_valid_in <= 1'b0;
      end
      pc_exp = pc_exp + 21'h00_0002;
    end
  endtask
  task reg_wr(input [2:0] a, input [7:0] d);
    begin
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      // idle edge so a following write never reassigns the strobe in one step
      @(posedge clk_in);
    end
  endtask
  task reg_rd(input [2:0] a, input [7:0] exp);
    begin
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_in);
      chk(reg_rdata_out, exp);
      @(posedge clk_in);
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    fail_count = fail_count + 1;
    end_of_test;
  end
  initial begin
    fail_count = 0;
    total_checks = 0;
    rnd_state = 32'h0001_6bf7;
    pc_exp = 21'h00_0000;
    reset_in = 1'b1;
    instr_valid_in = 1'b0;
    instr_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 3'h0;
    reg_wdata_in = 8'h00;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
    chk({instr_ready_out, pc_out, fptr_out}, {1'b1, 21'h00_0000, 36'h0_0000_0000});
    chk({stack_push_out, hold_we_out, file_rd_out, file_we_out, soft_reset_out, reg_rdata_out}, 13'h0000);
    @(posedge clk_in);
    for (k = 0; k < 3; k = k + 1) begin
      rnd_state = rnd_next(rnd_state);
      lit = (k == 0) ? 12'hfff : rnd_state[11:0];
      issue({8'hee, 2'h0, k[1:0], lit[11:8]}, 1'b1);
      issue({8'hf0, lit[7:0]}, 1'b0);
      @(negedge clk_in);
      chk(fptr_out[k*12 +: 12], lit);
      @(posedge clk_in);
    end
    $display("pointer load test done");
    rnd_state = rnd_next(rnd_state);
    bank = rnd_state[3:0];
    reg_wr(3'h0, {4'h0, bank});
    for (k = 0; k < 4; k = k + 1) begin
      rnd_state = rnd_next(rnd_state);
      f = (k == 0) ? 8'h00 : (k == 2) ? 8'h60 : rnd_state[7:0];
      v = file_init(file_addr(k[0], bank, f));
      issue({6'h14, k[1], k[0], f}, 1'b0);
      @(negedge clk_in);
      chk({file_rd_out, file_addr_out}, {1'b1, file_addr(k[0], bank, f)});
      @(negedge clk_in);
      chk({file_we_out, file_we_out ? file_wdata_out : 8'h00}, {k[1], k[1] ? v : 8'h00});
      @(posedge clk_in);
      reg_rd(3'h6, {6'h00, v[7], v == 8'h00});
      if (!k[1]) begin
        reg_rd(3'h5, v);
      end
    end
    $display("move file test done");
    for (k = 0; k < 4; k = k + 1) begin
      rnd_state = rnd_next(rnd_state);
      n = (k == 0) ? 11'h400 : (k == 1) ? 11'h3ff : rnd_state[10:0];
      p = pc_exp;
      issue({5'h1b, n}, 1'b0);
      pc_exp = p + 21'h00_0002 + {{9{n[10]}}, n, 1'b0};
      @(negedge clk_in);
      chk({stack_push_out, stack_top_out, instr_ready_out}, {1'b1, p + 21'h00_0002, 1'b0});
      chk(pc_out, pc_exp);
      @(posedge clk_in);
    end
    reg_rd(3'h7, pc_exp[7:0]);
    $display("relative call test done");
    for (k = 0; k < 8; k = k + 1) begin
      rnd_state = rnd_next(rnd_state);
      p = (k == 3) ? 21'h1f_ffff : (k == 6) ? 21'h00_0000 : rnd_state[20:0];
      lat = rnd_state[28:21];
      reg_wr(3'h2, p[7:0]);
      reg_wr(3'h3, p[15:8]);
      reg_wr(3'h4, {3'h0, p[20:16]});
      reg_wr(3'h1, lat);
      issue({14'h0003, k[1:0]}, 1'b0);
      q = (k[1:0] == 2'h3) ? p + 21'h00_0001 : p;
      @(negedge clk_in);
      @(negedge clk_in);
      chk({hold_we_out, hold_sel_out, hold_byte_hi_out, hold_data_out}, {1'b1, q[2:0], q[0], lat});
      @(posedge clk_in);
      p = (k[1:0] == 2'h2) ? p - 21'h00_0001 : (k[1:0] == 2'h0) ? p : p + 21'h00_0001;
      reg_rd(3'h2, p[7:0]);
      reg_rd(3'h4, {3'h0, p[20:16]});
    end
    $display("table write test done");
    reg_wr(3'h1, 8'ha5);
    reg_wr(3'h0, 8'h0c);
    issue(16'h00ff, 1'b0);
    @(negedge clk_in);
    chk(soft_reset_out, 1'b1);
    @(negedge clk_in);
    chk({soft_reset_out, pc_out, fptr_out}, 64'h0);
    @(posedge clk_in);
    reg_rd(3'h1, 8'h00);
    reg_rd(3'h0, 8'h00);
    $display("soft reset test done");
    end_of_test;
  end
endmodule // instr_subset_exec_tb_top
